// >>> hdl/acir_map.svh
// Constants of the converter injection result block.
`ifndef ACIR_MAP_SVH
`define ACIR_MAP_SVH
`define ACIR_DATA_W 10
`define ACIR_CHAN_W 5
`define ACIR_FIFO_DEPTH 4
`define ACIR_CONV_TIME_NS 3000
`define ACIR_CLK_NS 40
`define ACIR_CONV_CYCLES ((`ACIR_CONV_TIME_NS + `ACIR_CLK_NS - 1) / `ACIR_CLK_NS)
`define ACIR_CNT_W 7
`define ACIR_RESULT_RST 10'h000
`endif

// >>> hdl/acir_pkg.sv
// Types of the converter injection result block.
`include "acir_map.svh"
package acir_pkg;
   typedef logic [`ACIR_DATA_W-1:0] acir_data_t;
   typedef logic [`ACIR_CHAN_W-1:0] acir_chan_t;
   typedef enum logic [1:0] {
      ACIR_IDLE = 2'b00,
      ACIR_CONV = 2'b01,
      ACIR_STALL = 2'b10
   } acir_state_t;
endpackage

// >>> hdl/acir_if.sv
// Interface joining the converter end and the result reader end.
`timescale 1ns/100ps
`default_nettype none
interface acir_if;
   import acir_pkg::*;
   logic inj_req;
   acir_chan_t inj_chan;
   logic inj_busy;
   logic wait_read_en;
   acir_data_t alt_result_reg;
   logic inj_done_irq;
   logic alt_rd;
   acir_data_t std_result_reg;
   logic std_valid;
   logic std_ready;
   modport dev (input inj_req, input inj_chan, output inj_busy, input wait_read_en,
      output alt_result_reg, output inj_done_irq, input alt_rd, output std_result_reg,
      output std_valid, input std_ready);
   modport rdr (output inj_req, output inj_chan, input inj_busy, output wait_read_en,
      input alt_result_reg, input inj_done_irq, output alt_rd, input std_result_reg,
      input std_valid, output std_ready);
endinterface
`default_nettype wire

// >>> hdl/acir_fifo.sv
// Small valid/ready FIFO for standard conversion results.
`timescale 1ns/100ps
`default_nettype none
module acir_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 4
) (
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [AW:0] cnt_r, cnt_nxt;
   logic wr, rd;
   always_comb begin
      o_in_ready = (cnt_r != (AW+1)'(DEPTH));
      o_out_valid = (cnt_r != '0);
      o_out_data = mem_r[rp_r];
      wr = i_in_valid && o_in_ready;
      rd = o_out_valid && i_out_ready;
      wp_nxt = wr ? AW'(wp_r + 1'b1) : wp_r;
      rp_nxt = rd ? AW'(rp_r + 1'b1) : rp_r;
      cnt_nxt = (AW+1)'(cnt_r + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd});
   end
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end
   always_ff @(posedge i_sys_clk) begin
      if (wr) begin
         mem_r[wp_r] <= i_in_data;
      end
   end
endmodule // acir_fifo
`default_nettype wire

// >>> hdl/acir_conv.sv
// Converter end: conversion sequencing, alternate result and holding register.
// Function
// - Injection converts one channel, mode unchanged.
// - Software keeps wait-for-read on during injection.
// - Injected result to alternate register, flag raised.
// - Occupied holding register suspends next conversion.
// - Injection while unread result waits in holding.
// - Alternate read moves injected holding value, raises flag.
// - Second early injection never stalls permanently.
// - A single alternate read releases a stall on a held injected result.
// - Toggling wait-for-read mode releases a stall.
// - Compare channel triggers, event transfer reads results.
// - Reader services injected results only with i_xfer_en set; the bench fires three injections with it clear.
`timescale 1ns/100ps
`default_nettype none
`include "acir_map.svh"
module acir_conv
   import acir_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_reset,
   acir_if.dev bus,
   input wire logic i_scan_en,
   input wire logic [`ACIR_CHAN_W-1:0] i_scan_chan,
   input wire logic [`ACIR_DATA_W-1:0] i_adc_sample,
   output logic [`ACIR_CHAN_W-1:0] o_adc_chan,
   output logic o_stalled
);
   acir_state_t st_r, st_nxt;
   logic [`ACIR_CNT_W-1:0] cnt_r, cnt_nxt;
   logic inj_pend_r, inj_pend_nxt;
   logic cur_inj_r, cur_inj_nxt;
   acir_chan_t inj_chan_r, inj_chan_nxt;
   acir_chan_t chan_r, chan_nxt;
   acir_data_t alt_r, alt_nxt;
   logic alt_full_r, alt_full_nxt;
   acir_data_t hold_r, hold_nxt;
   logic hold_full_r, hold_full_nxt;
   logic hold_inj_r, hold_inj_nxt;
   logic irq_r, irq_nxt;
   logic stalled_r, stalled_nxt;
   logic wr_en_r, wr_en_nxt;
   acir_data_t std_data;
   logic std_push;
   // Input side of the local queue; the reader's own ready is a separate signal.
   logic std_ready;
   logic done;

   // A request counts only when no earlier one is still waiting to start.
   function automatic logic take_req(input logic req, input logic pend);
      take_req = req && !pend;
   endfunction

   // The queue lets the reader miss a few cycles without holding up scan results.
   acir_fifo #(.WIDTH(`ACIR_DATA_W), .DEPTH(`ACIR_FIFO_DEPTH)) u_std_fifo (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .i_in_valid(std_push),
      .o_in_ready(std_ready),
      .i_in_data(std_data),
      .o_out_valid(bus.std_valid),
      .i_out_ready(bus.std_ready),
      .o_out_data(bus.std_result_reg)
   );
   assign bus.alt_result_reg = alt_r;
   assign bus.inj_done_irq = irq_r;
   assign bus.inj_busy = inj_pend_r;
   assign o_adc_chan = chan_r;
   assign o_stalled = stalled_r;
   // The count runs from zero, so the last cycle of a conversion is one below its length.
   assign done = (st_r == ACIR_CONV) && (cnt_r == `ACIR_CNT_W'(`ACIR_CONV_CYCLES - 1));

   // Every register holds unless a branch below changes it; the flag defaults low and wr_en_nxt follows the mode.
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      inj_pend_nxt = inj_pend_r;
      inj_chan_nxt = inj_chan_r;
      cur_inj_nxt = cur_inj_r;
      chan_nxt = chan_r;
      alt_nxt = alt_r;
      alt_full_nxt = alt_full_r;
      hold_nxt = hold_r;
      hold_full_nxt = hold_full_r;
      hold_inj_nxt = hold_inj_r;
      irq_nxt = 1'b0;
      std_push = 1'b0;
      std_data = i_adc_sample;
      wr_en_nxt = bus.wait_read_en;
      // Requests are latched so a trigger during a busy conversion is not lost.
      if (take_req(bus.inj_req, inj_pend_r)) begin
         inj_pend_nxt = 1'b1;
         inj_chan_nxt = bus.inj_chan;
      end
      // A read of the alternate result frees it; an injected holding value moves in. Disabling
      // wait-for-read also releases the alternate register and drains an injected holding value.
      // Only the falling edge counts; holding the mode off does not release twice.
      if (bus.alt_rd || (wr_en_r && !bus.wait_read_en)) begin
         alt_full_nxt = 1'b0;
         if (hold_full_r && hold_inj_r) begin
            alt_nxt = hold_r;
            alt_full_nxt = bus.wait_read_en;
            hold_full_nxt = 1'b0;
            // Raising the flag on the move is what keeps a second early injection from
            // locking the converter: the reader learns of the value and reads it again.
            irq_nxt = 1'b1;
         end
      end
      // A held standard result drains into the queue as soon as it has room.
      if (hold_full_r && !hold_inj_r && std_ready) begin
         std_push = 1'b1;
         std_data = hold_r;
         hold_full_nxt = 1'b0;
      end
      unique case (st_r)
         ACIR_IDLE: begin
            if (hold_full_r) begin
               st_nxt = ACIR_STALL;
            end else if (inj_pend_r || take_req(bus.inj_req, inj_pend_r)) begin
               // Injection goes before scan, so outside a stall a trigger waits at most one conversion.
               st_nxt = ACIR_CONV;
               cur_inj_nxt = 1'b1;
               chan_nxt = inj_pend_r ? inj_chan_r : bus.inj_chan;
               inj_pend_nxt = 1'b0;
               cnt_nxt = '0;
            end else if (i_scan_en) begin
               st_nxt = ACIR_CONV;
               cur_inj_nxt = 1'b0;
               chan_nxt = i_scan_chan;
               cnt_nxt = '0;
            end
         end
         ACIR_CONV: begin
            cnt_nxt = `ACIR_CNT_W'(cnt_r + 1'b1);
            if (done) begin
               st_nxt = ACIR_IDLE;
               cnt_nxt = '0;
               if (cur_inj_r) begin
                  // A read in this same cycle has already cleared the full flag, so the
                  // new result then lands in the alternate register at once.
                  if (alt_full_nxt) begin
                     hold_nxt = i_adc_sample;
                     hold_full_nxt = 1'b1;
                     hold_inj_nxt = 1'b1;
                  end else begin
                     alt_nxt = i_adc_sample;
                     alt_full_nxt = bus.wait_read_en;
                     irq_nxt = 1'b1;
                  end
               end else if (std_ready && !hold_full_nxt) begin
                  std_push = 1'b1;
                  std_data = i_adc_sample;
               end else begin
                  hold_nxt = i_adc_sample;
                  hold_full_nxt = 1'b1;
                  hold_inj_nxt = 1'b0;
               end
            end
         end
         ACIR_STALL: begin
            // Once the holding register drains, a waiting injection starts from idle.
            if (!hold_full_r) begin
               st_nxt = ACIR_IDLE;
            end
         end
         default: begin
            st_nxt = ACIR_IDLE;
         end
      endcase
      // Taken from the next state so the pin is a flop output without a cycle of lag.
      stalled_nxt = (st_nxt == ACIR_STALL);
   end

   // Registers only; all decisions are made above.
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         st_r <= ACIR_IDLE;
         cnt_r <= '0;
         inj_pend_r <= 1'b0;
         inj_chan_r <= '0;
         cur_inj_r <= 1'b0;
         chan_r <= '0;
         alt_r <= `ACIR_RESULT_RST;
         alt_full_r <= 1'b0;
         hold_r <= `ACIR_RESULT_RST;
         hold_full_r <= 1'b0;
         hold_inj_r <= 1'b0;
         irq_r <= 1'b0;
         stalled_r <= 1'b0;
         wr_en_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         inj_pend_r <= inj_pend_nxt;
         inj_chan_r <= inj_chan_nxt;
         cur_inj_r <= cur_inj_nxt;
         chan_r <= chan_nxt;
         alt_r <= alt_nxt;
         alt_full_r <= alt_full_nxt;
         hold_r <= hold_nxt;
         hold_full_r <= hold_full_nxt;
         hold_inj_r <= hold_inj_nxt;
         irq_r <= irq_nxt;
         stalled_r <= stalled_nxt;
         wr_en_r <= wr_en_nxt;
      end
   end
endmodule // acir_conv
`default_nettype wire

// >>> hdl/acir_reader.sv
// Reader end: trigger from a compare event, collect injected and standard results.
`timescale 1ns/100ps
`default_nettype none
`include "acir_map.svh"
module acir_reader
   import acir_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_reset,
   acir_if.rdr bus,
   input wire logic i_compare_evt,
   input wire logic [`ACIR_CHAN_W-1:0] i_inj_chan,
   input wire logic i_wait_read_en,
   input wire logic i_xfer_en,
   output logic [`ACIR_DATA_W-1:0] o_inj_result,
   output logic o_inj_valid,
   output logic [`ACIR_DATA_W-1:0] o_std_result,
   output logic o_std_valid
);
   logic req_r, req_nxt;
   logic rd_r, rd_nxt;
   logic inj_v_r, inj_v_nxt;
   logic std_v_r, std_v_nxt;
   logic wen_r, wen_nxt;
   acir_chan_t chan_r, chan_nxt;
   acir_data_t inj_d_r, inj_d_nxt;
   acir_data_t std_d_r, std_d_nxt;
   assign bus.inj_req = req_r;
   assign bus.inj_chan = chan_r;
   assign bus.alt_rd = rd_r;
   assign bus.wait_read_en = wen_r;
   assign bus.std_ready = 1'b1;
   assign o_inj_result = inj_d_r;
   assign o_inj_valid = inj_v_r;
   assign o_std_result = std_d_r;
   assign o_std_valid = std_v_r;
   always_comb begin
      wen_nxt = i_wait_read_en;
      req_nxt = i_compare_evt && !bus.inj_busy;
      chan_nxt = i_inj_chan;
      // The event transfer reads once per completion flag.
      rd_nxt = bus.inj_done_irq && i_xfer_en;
      inj_v_nxt = bus.inj_done_irq && i_xfer_en;
      inj_d_nxt = bus.inj_done_irq ? bus.alt_result_reg : inj_d_r;
      std_v_nxt = bus.std_valid;
      std_d_nxt = bus.std_valid ? bus.std_result_reg : std_d_r;
   end
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         req_r <= 1'b0;
         chan_r <= '0;
         rd_r <= 1'b0;
         inj_v_r <= 1'b0;
         std_v_r <= 1'b0;
         wen_r <= 1'b0;
         inj_d_r <= `ACIR_RESULT_RST;
         std_d_r <= `ACIR_RESULT_RST;
      end else begin
         req_r <= req_nxt;
         chan_r <= chan_nxt;
         rd_r <= rd_nxt;
         inj_v_r <= inj_v_nxt;
         std_v_r <= std_v_nxt;
         wen_r <= wen_nxt;
         inj_d_r <= inj_d_nxt;
         std_d_r <= std_d_nxt;
      end
   end
endmodule // acir_reader
`default_nettype wire

// >>> dv/acir_monitor.sv
// Assertions on the signals that join the converter end and the reader end.
`timescale 1ns/100ps
`default_nettype none
module acir_monitor
   import acir_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_inj_req,
   input wire logic i_inj_busy,
   input wire logic i_alt_rd,
   input wire logic i_inj_done_irq,
   input wire acir_data_t i_alt_result_reg,
   input wire logic i_std_valid,
   input wire logic i_std_ready
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);
   property p_irq_pulse; i_inj_done_irq |=> !i_inj_done_irq; endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("irq held too long");
   property p_alt_irq; $changed(i_alt_result_reg) |-> i_inj_done_irq; endproperty
   a_alt_irq: assert property (p_alt_irq) else $error("silent alt load");
   property p_req_answer; i_inj_req && !i_inj_busy |-> ##[1:1000] i_inj_done_irq; endproperty
   a_req_answer: assert property (p_req_answer) else $error("request unanswered");
   property p_busy_answer; $fell(i_inj_busy) |-> ##[1:1000] i_inj_done_irq; endproperty
   a_busy_answer: assert property (p_busy_answer) else $error("start unanswered");
   property p_busy_clears; i_inj_busy |-> ##[1:1000] !i_inj_busy; endproperty
   a_busy_clears: assert property (p_busy_clears) else $error("busy stuck");
   property p_req_pulse; i_inj_req |=> !i_inj_req; endproperty
   a_req_pulse: assert property (p_req_pulse) else $error("request not a pulse");
   property p_rd_pulse; i_alt_rd |=> !i_alt_rd; endproperty
   a_rd_pulse: assert property (p_rd_pulse) else $error("read not a pulse");
   property p_std_ready; i_std_valid |-> i_std_ready; endproperty
   a_std_ready: assert property (p_std_ready) else $error("standard result stalled");
endmodule // acir_monitor
`default_nettype wire

// >>> dv/adc_channel_injection_result_test.sv
// Self-checking bench for the injection result path with both ends joined.
`timescale 1ns/100ps
`default_nettype none
module adc_channel_injection_result_test;
   import acir_pkg::*;
   logic i_sys_clk = 1'b0;
   logic i_reset = 1'b1;
   logic scan_en = 1'b0;
   acir_chan_t scan_chan = 5'h03;
   acir_data_t sample = 10'h000;
   logic cmp_evt = 1'b0;
   acir_chan_t inj_chan = 5'h00;
   logic wait_rd = 1'b1;
   logic xfer_en = 1'b1;
   acir_chan_t adc_chan;
   logic stalled;
   acir_data_t inj_res;
   logic inj_val;
   acir_data_t std_res;
   logic std_val;
   int miscompares = 0;
   int num_checks = 0;
   acir_if bus_if ();
   always #20 i_sys_clk = ~i_sys_clk;
   acir_conv acir_conv_i (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .bus(bus_if.dev),
      .i_scan_en(scan_en), .i_scan_chan(scan_chan), .i_adc_sample(sample),
      .o_adc_chan(adc_chan), .o_stalled(stalled));
   acir_reader acir_reader_i (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .bus(bus_if.rdr),
      .i_compare_evt(cmp_evt), .i_inj_chan(inj_chan), .i_wait_read_en(wait_rd),
      .i_xfer_en(xfer_en), .o_inj_result(inj_res), .o_inj_valid(inj_val),
      .o_std_result(std_res), .o_std_valid(std_val));
   acir_monitor acir_monitor_i (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
      .i_inj_req(bus_if.inj_req), .i_inj_busy(bus_if.inj_busy), .i_alt_rd(bus_if.alt_rd),
      .i_inj_done_irq(bus_if.inj_done_irq), .i_alt_result_reg(bus_if.alt_result_reg),
      .i_std_valid(bus_if.std_valid), .i_std_ready(bus_if.std_ready));
   task automatic finish_test();
      $display("checks %0d, mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic check(input acir_data_t got, input acir_data_t exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // A request is a one-cycle compare event; the sample is what the converter will see.
   task automatic fire(input acir_chan_t ch, input acir_data_t smp);
      inj_chan = ch;
      sample = smp;
      cmp_evt = 1'b1;
      @(negedge i_sys_clk);
      cmp_evt = 1'b0;
   endtask
   task automatic chan_seen(input acir_chan_t ch);
      int n;
      n = 0;
      while (adc_chan !== ch && n < 8) begin
         @(negedge i_sys_clk);
         n++;
      end
      check(acir_data_t'(adc_chan), acir_data_t'(ch));
   endtask
   // Result outputs are one-cycle pulses, so they are polled on every falling edge.
   task automatic wait_res(input logic is_std, input acir_data_t exp);
      int n;
      n = 0;
      while ((is_std ? std_val : inj_val) !== 1'b1 && n < 500) begin
         @(negedge i_sys_clk);
         n++;
      end
      if ((is_std ? std_val : inj_val) !== 1'b1) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, is_std ? std_res : inj_res, exp);
         finish_test();
      end else begin
         check(is_std ? std_res : inj_res, exp);
         @(negedge i_sys_clk);
      end
   endtask
   initial begin
      repeat (2) @(negedge i_sys_clk);
      i_reset = 1'b0;
      fire(5'h07, 10'h2a5);
      chan_seen(5'h07);
      wait_res(1'b0, 10'h2a5);
      $display("test single injection done");
      scan_en = 1'b1;
      wait_res(1'b1, 10'h2a5);
      fire(5'h11, 10'h15a);
      wait_res(1'b0, 10'h15a);
      wait_res(1'b1, 10'h15a);
      scan_en = 1'b0;
      $display("test injection during scan done");
      repeat (100) @(negedge i_sys_clk);
      xfer_en = 1'b0;
      fire(5'h01, 10'h0f0);
      repeat (90) @(negedge i_sys_clk);
      fire(5'h02, 10'h30c);
      repeat (90) @(negedge i_sys_clk);
      fire(5'h04, 10'h111);
      repeat (10) @(negedge i_sys_clk);
      check(acir_data_t'(stalled), 10'h001);
      check(bus_if.alt_result_reg, 10'h0f0);
      xfer_en = 1'b1;
      wait_rd = 1'b0;
      @(negedge i_sys_clk);
      wait_rd = 1'b1;
      wait_res(1'b0, 10'h30c);
      wait_res(1'b0, 10'h111);
      check(acir_data_t'(stalled), 10'h000);
      $display("test holding release done");
      i_reset = 1'b1;
      repeat (2) @(negedge i_sys_clk);
      i_reset = 1'b0;
      check(bus_if.alt_result_reg, 10'h000);
      fire(5'h1f, 10'h3ff);
      wait_res(1'b0, 10'h3ff);
      $display("test reset and rerun done");
      finish_test();
   end
endmodule // adc_channel_injection_result_test
`default_nettype wire
